// [core/fifo_stage_cfg.svh]
// Constants for one cascadable FIFO stage: sizes, pin-sync layout, fixed latencies.
// Assumes a single 200 MHz core clock; included by the package and the bench.
`ifndef FIFO_STAGE_CFG_SVH
`define FIFO_STAGE_CFG_SVH

`define FS_WIDTH          18
`define FS_AW             13
`define FS_DEPTH          14'h2000
`define FS_PTR_ZERO       14'h0000
`define FS_PTR_ONE        14'h0001
`define FS_PIN_W          24
`define FS_PIN_RST        24'h3C0000
`define FS_FIXED_LAT_NS   60
`define FS_CLK_PERIOD_NS  5
`define FS_LAT_CYCLES     ((`FS_FIXED_LAT_NS + `FS_CLK_PERIOD_NS - 1) / `FS_CLK_PERIOD_NS)
`define FS_RCLK_STD       2'h1
`define FS_RCLK_FALL_THROUGH_MODE      2'h2
`define FS_LAT_ZERO       4'h0

`endif

// [core/fifo_stage_pkg.sv]
// Types shared by the cascadable FIFO stage.
// Assumes fifo_stage_cfg.svh is on the include path.
`include "fifo_stage_cfg.svh"

package fifo_stage_pkg;

  typedef struct packed {
    logic                 wr_clk;
    logic                 rd_clk;
    logic                 wr_en_n;
    logic                 rd_en_n;
    logic                 master_reset_n;
    logic                 retransmit_n;
    logic [`FS_WIDTH-1:0] data;
  } pins_t;

  typedef enum logic [1:0] {
    ST_EMPTY     = 2'b00,
    ST_WAIT_NS   = 2'b01,
    ST_WAIT_RCLK = 2'b10,
    ST_OPEN      = 2'b11
  } stage_state_t;

endpackage

// [core/fifo_stage.sv]
// One FIFO stage that cascades in width (shared controls) or depth (fall-through chain).
// Assumes writer and reader clocks arrive as pins, unrelated to core_clk_in and slower.
// Summary of operation
// - Depth chaining only in fall-through mode.
// - First word ripples down without reads.
// - Valid flag low when word shown; writes next.
// - Only first word sees propagation latency.
// - Freed slot drives ready low, bubbling up.
// - First word latency 60ns plus read clocks.
// - Retransmit latency 60ns plus read clocks.
// - Write and read clocks may vary or stop.
`timescale 1ns/1ps

module fifo_stage
  import fifo_stage_pkg::*;
(
  input  wire logic                 core_clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 wr_clk_in,
  input  wire logic                 wr_en_n_in,
  input  wire logic [`FS_WIDTH-1:0] data_in,
  input  wire logic                 rd_clk_in,
  input  wire logic                 rd_en_n_in,
  input  wire logic                 master_reset_n_in,
  input  wire logic                 retransmit_n_in,
  input  wire logic                 fall_through_mode_in,
  input  wire logic                 legacy_frequency_select_in,
  output logic      [`FS_WIDTH-1:0] data_out,
  output logic                      empty_flag_n_out,
  output logic                      full_flag_n_out,
  output logic                      out_valid_n_out,
  output logic                      in_ready_n_out,
  output logic                      fall_through_mode_out
);

  pins_t                raw;
  logic [`FS_PIN_W-1:0] sync1;
  logic [`FS_PIN_W-1:0] sync2;
  logic [`FS_PIN_W-1:0] sync3;
  pins_t                filt;
  pins_t                prev;
  logic                 fall_through_mode;
  logic                 mode_pin;
  stage_state_t         state;
  stage_state_t         next_state;
  logic [3:0]           lat_cnt;
  logic [3:0]           next_lat_cnt;
  logic [1:0]           rclk_cnt;
  logic [1:0]           next_rclk_cnt;
  logic [`FS_AW:0]      wr_ptr;
  logic [`FS_AW:0]      rd_ptr;
  logic [`FS_AW:0]      next_wr_ptr;
  logic [`FS_AW:0]      next_rd_ptr;
  logic [`FS_WIDTH-1:0] mem [0:(1<<`FS_AW)-1];

  // Frequency select is a don't-care; it is deliberately never read
  assign raw = '{wr_clk: wr_clk_in, rd_clk: rd_clk_in, wr_en_n: wr_en_n_in,
                 rd_en_n: rd_en_n_in, master_reset_n: master_reset_n_in,
                 retransmit_n: retransmit_n_in, data: data_in};

  localparam logic [`FS_PIN_W-1:0] RST_VEC = `FS_PIN_RST;

  // Every pin but the mode strap and frequency select passes the same three sync stages and glitch filter so data stays aligned with its clock edge
  for (genvar i = 0; i < `FS_PIN_W; i++) begin : g_pin_sync
    localparam logic RST_BIT = RST_VEC[i];
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        sync1[i] <= RST_BIT;
        sync2[i] <= RST_BIT;
        sync3[i] <= RST_BIT;
        filt[i]  <= RST_BIT;
        prev[i]  <= RST_BIT;
      end else begin
        sync1[i] <= raw[i];
        sync2[i] <= sync1[i];
        sync3[i] <= sync2[i];
        prev[i]  <= filt[i];
        if (sync2[i] == sync3[i]) begin
          filt[i] <= sync3[i];
        end
      end
    end
  end

  // Edges are seen only when they happen, so stopped clocks simply stall
  wire                  wr_edge   = filt.wr_clk & ~prev.wr_clk;
  wire                  rd_edge   = filt.rd_clk & ~prev.rd_clk;
  wire                  rt_fall   = ~filt.retransmit_n & prev.retransmit_n;
  wire                  mreset    = ~filt.master_reset_n;
  wire [`FS_AW:0]       count     = wr_ptr - rd_ptr;
  wire                  mem_full  = (count == `FS_DEPTH);
  wire                  mem_some  = (count != `FS_PTR_ZERO);
  wire                  do_write  = wr_edge & ~filt.wr_en_n & ~mem_full;
  wire                  rd_req    = rd_edge & ~filt.rd_en_n & (state == ST_OPEN);
  wire                  open_now  = (state == ST_WAIT_RCLK) & rd_edge & (rclk_cnt == 2'h1);
  wire                  pop       = ~rt_fall & mem_some &
                                    ((fall_through_mode & open_now) | rd_req);
  wire [`FS_AW-1:0]     rd_addr   = rd_ptr[`FS_AW-1:0];
  wire [`FS_AW:0]       next_cnt  = next_wr_ptr - next_rd_ptr;
  wire [1:0]            rclk_need = fall_through_mode ? `FS_RCLK_FALL_THROUGH_MODE : `FS_RCLK_STD;

  always_comb begin
    next_state    = state;
    next_lat_cnt  = lat_cnt;
    next_rclk_cnt = rclk_cnt;
    next_wr_ptr   = do_write ? wr_ptr + `FS_PTR_ONE : wr_ptr;
    next_rd_ptr   = pop ? rd_ptr + `FS_PTR_ONE : rd_ptr;
    case (state)
      ST_EMPTY: begin
        if (mem_some) begin
          next_state   = ST_WAIT_NS;
          next_lat_cnt = 4'(`FS_LAT_CYCLES - 1);
        end
      end
      ST_WAIT_NS: begin
        if (lat_cnt == `FS_LAT_ZERO) begin
          next_state    = ST_WAIT_RCLK;
          next_rclk_cnt = rclk_need;
        end else begin
          next_lat_cnt = lat_cnt - 4'h1;
        end
      end
      ST_WAIT_RCLK: begin
        // No read enable needed: the stage opens by itself, and in fall-through mode the word is loaded too
        if (open_now) begin
          next_state = ST_OPEN;
        end else if (rd_edge) begin
          next_rclk_cnt = rclk_cnt - 2'h1;
        end
      end
      ST_OPEN: begin
        // Later words follow without another latency wait
        if (rd_req && !mem_some) begin
          next_state = ST_EMPTY;
        end else if (rd_req && !fall_through_mode && count == `FS_PTR_ONE && !do_write) begin
          next_state = ST_EMPTY;
        end
      end
      default: next_state = ST_EMPTY;
    endcase
    // Retransmit rewinds and pays the same fixed latency again
    if (rt_fall) begin
      next_state  = ST_EMPTY;
      next_rd_ptr = `FS_PTR_ZERO;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (do_write) begin
      mem[wr_ptr[`FS_AW-1:0]] <= filt.data;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state    <= ST_EMPTY;
      lat_cnt  <= `FS_LAT_ZERO;
      rclk_cnt <= `FS_RCLK_STD;
      wr_ptr   <= `FS_PTR_ZERO;
      rd_ptr   <= `FS_PTR_ZERO;
    end else if (mreset) begin
      state    <= ST_EMPTY;
      lat_cnt  <= `FS_LAT_ZERO;
      rclk_cnt <= `FS_RCLK_STD;
      wr_ptr   <= `FS_PTR_ZERO;
      rd_ptr   <= `FS_PTR_ZERO;
    end else begin
      state    <= next_state;
      lat_cnt  <= next_lat_cnt;
      rclk_cnt <= next_rclk_cnt;
      wr_ptr   <= next_wr_ptr;
      rd_ptr   <= next_rd_ptr;
    end
  end

  // Mode is taken only while master reset is held, the strap is synced first
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_pin <= 1'b0;
      fall_through_mode     <= 1'b0;
    end else begin
      mode_pin <= fall_through_mode_in;
      if (mreset) begin
        fall_through_mode <= mode_pin;
      end
    end
  end

  wire next_open = ~mreset & (next_state == ST_OPEN);
  wire next_full = ~mreset & (next_cnt == `FS_DEPTH);

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_out              <= '0;
      empty_flag_n_out      <= 1'b0;
      full_flag_n_out       <= 1'b1;
      out_valid_n_out       <= 1'b1;
      in_ready_n_out        <= 1'b0;
      fall_through_mode_out <= 1'b0;
    end else begin
      if (pop) begin
        data_out <= mem[rd_addr];
      end
      empty_flag_n_out      <= ~fall_through_mode & next_open;
      full_flag_n_out       <= fall_through_mode | ~next_full;
      out_valid_n_out       <= ~(fall_through_mode & next_open);
      in_ready_n_out        <= fall_through_mode & next_full;
      fall_through_mode_out <= fall_through_mode;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in || mreset);

  chk_ns_wait: assert property ($rose(state == ST_WAIT_NS) && !rt_fall |->
    lat_cnt == 4'(`FS_LAT_CYCLES - 1) ##11 (state == ST_WAIT_NS && lat_cnt == `FS_LAT_ZERO)
    ##1 (state != ST_WAIT_NS))
    else $error("fixed latency wait not twelve cycles");
  chk_rclk_open: assert property (open_now && !rt_fall |=> state == ST_OPEN)
    else $error("word did not fall through on final read clock");
  chk_rclk_count: assert property ($rose(state == ST_WAIT_RCLK) |->
    rclk_cnt == (fall_through_mode ? `FS_RCLK_FALL_THROUGH_MODE : `FS_RCLK_STD))
    else $error("read clock count wrong for mode");
  chk_valid_flag: assert property (fall_through_mode |-> out_valid_n_out == (state != ST_OPEN))
    else $error("valid flag disagrees with state");
  chk_std_empty: assert property (!fall_through_mode |-> empty_flag_n_out == (state == ST_OPEN))
    else $error("empty flag disagrees with state");
  chk_no_redelay: assert property (state == ST_OPEN && count > `FS_PTR_ONE && !rt_fall
    |=> state == ST_OPEN)
    else $error("stage left open state with words stored");
  chk_ready_free: assert property (fall_through_mode && in_ready_n_out && pop && !do_write
    |=> !in_ready_n_out)
    else $error("freed slot did not lower ready");
  chk_fall_load: assert property (fall_through_mode && open_now && !rt_fall |=>
    rd_ptr == $past(rd_ptr) + `FS_PTR_ONE)
    else $error("fall-through word not loaded on open");
  chk_clock_stop: assert property (state == ST_WAIT_RCLK && !rd_edge && !rt_fall
    |=> state == ST_WAIT_RCLK && $stable(rd_ptr))
    else $error("progress without read clock edge");
  chk_rt_rewind: assert property (rt_fall |=> state == ST_EMPTY && rd_ptr == `FS_PTR_ZERO)
    else $error("retransmit did not rewind");

  cov_fall_through_mode_open: cover property (fall_through_mode && open_now);
  cov_std_read: cover property (!fall_through_mode && rd_req && pop);
  cov_retransmit: cover property (rt_fall && state == ST_OPEN);
  cov_full: cover property (mem_full && wr_edge && !filt.wr_en_n);

endmodule // fifo_stage

// [tb/read_clock_model.sv]
// Reader-side clock source that paces the stage's read clock pin.
// Assumes the core clock drives it; one pin period is ten core cycles.
`timescale 1ns/1ps

module read_clock_model (
  input  wire logic core_clk_in,
  input  wire logic run_in,
  output logic      rd_clk_out
);
  logic [2:0] tick;

  // Parks low when stopped, so no stray edge leaks into the stage
  always_ff @(posedge core_clk_in) begin
    if (!run_in) begin
      tick       <= 3'h0;
      rd_clk_out <= 1'b0;
    end else if (tick == 3'h4) begin
      tick       <= 3'h0;
      rd_clk_out <= ~rd_clk_out;
    end else begin
      tick <= tick + 3'h1;
    end
  end
endmodule // read_clock_model

// [tb/fifo_width_depth_expansion_bench.sv]
// Self-checking bench for one stage in standard and fall-through use.
// Assumes the read clock model paces rd_clk_in at a tenth of the core rate.
`timescale 1ns/1ps
`include "fifo_stage_cfg.svh"

module fifo_width_depth_expansion_bench;
  logic                 clk, rst_n, wr_clk, wen_n, ren_n, mrs_n, ftm, run, rd_clk, rt_n;
  logic [`FS_WIDTH-1:0] din, dout;
  logic                 empty_n, full_n, valid_n, ready_n, mode;
  logic [4:0]           flags;
  int                   n_mismatch, comparisons;

  // A lone stage: composite AND/OR of its flags is the flag itself
  assign flags = {mode, ready_n, valid_n, full_n, empty_n};

  // One device: shared controls, equal depth, no skew margin
  fifo_stage dut (.core_clk_in(clk), .rst_n_in(rst_n), .wr_clk_in(wr_clk), .wr_en_n_in(wen_n),
    .data_in(din), .rd_clk_in(rd_clk), .rd_en_n_in(ren_n), .master_reset_n_in(mrs_n),
    .retransmit_n_in(rt_n), .fall_through_mode_in(ftm), .legacy_frequency_select_in(1'b0),
    .data_out(dout), .empty_flag_n_out(empty_n), .full_flag_n_out(full_n),
    .out_valid_n_out(valid_n), .in_ready_n_out(ready_n), .fall_through_mode_out(mode));

  read_clock_model reader (.core_clk_in(clk), .run_in(run), .rd_clk_out(rd_clk));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [17:0] exp, input logic [17:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Bounded wait on one flag bit, sampled mid-cycle where it has settled
  task automatic wait_for(input int b, input logic v, input string name);
    int i;
    for (i = 0; i < 80 && flags[b] !== v; i++) @(negedge clk);
    chk(name, {17'h00000, v}, {17'h00000, flags[b]});
    if (i == 80) complete_run();
  endtask

  // Data and enable settle a cycle before the pin edge; 4 high, then 3 low
  task automatic wr(input logic [17:0] d, input logic en_n);
    @(posedge clk);
    din   <= d;
    wen_n <= en_n;
    @(posedge clk);
    wr_clk <= 1'b1;
    repeat (4) @(posedge clk);
    wr_clk <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Enable spans one full read clock period, so exactly one rise sees it
  task automatic rd;
    @(posedge clk);
    ren_n <= 1'b0;
    repeat (10) @(posedge clk);
    ren_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  task automatic master_reset(input logic m);
    @(posedge clk);
    ftm   <= m;
    mrs_n <= 1'b0;
    repeat (10) @(posedge clk);
    mrs_n <= 1'b1;
    repeat (10) @(posedge clk);
  endtask

  initial begin
    rst_n = 1'b0; wr_clk = 1'b0; wen_n = 1'b1; ren_n = 1'b1; mrs_n = 1'b1;
    ftm = 1'b0; run = 1'b0; din = 18'h00000; n_mismatch = 0; comparisons = 0; rt_n = 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    run   <= 1'b1;
    @(negedge clk);
    chk("reset flags", 18'h00006, {13'h0000, flags});
    master_reset(1'b0);
    wr(18'h2A5A5, 1'b0);
    repeat (6) @(negedge clk);
    chk("empty early", 18'h00000, {17'h00000, empty_n});
    wait_for(0, 1'b1, "empty_n up");
    rd;
    chk("std data", 18'h2A5A5, dout);
    wait_for(0, 1'b0, "empty_n down");
    @(posedge clk);
    run <= 1'b0;
    master_reset(1'b1);
    @(negedge clk);
    chk("fall_through_mode flags", 18'h00016, {13'h0000, flags});
    wr(18'h11111, 1'b1);
    wr(18'h1C3C3, 1'b0);
    repeat (40) @(negedge clk);
    chk("valid stopped", 18'h00001, {17'h00000, valid_n});
    @(posedge clk);
    run <= 1'b1;
    wait_for(2, 1'b0, "valid_n fall");
    chk("fall data", 18'h1C3C3, dout);
    rd;
    wait_for(2, 1'b1, "valid_n drained");
    @(posedge clk);
    rt_n <= 1'b0;
    repeat (6) @(posedge clk);
    rt_n <= 1'b1;
    wait_for(2, 1'b0, "valid_n rewind");
    chk("rewind data", 18'h1C3C3, dout);
    master_reset(1'b1);
    for (int i = 0; i < 8193; i++) wr(i[17:0], 1'b0);
    wait_for(3, 1'b1, "ready_n full");
    chk("head", 18'h00000, dout);
    rd;
    wait_for(3, 1'b0, "ready_n freed");
    chk("next head", 18'h00001, dout);
    complete_run();
  end
endmodule // fifo_width_depth_expansion_bench
